// >>> rtc_calendar_calibration_core.sv
// RTC clock/calendar counters, rate calibration and test pin, with bus slave
//
// Behaviour
// - Only low six register address bits decode; higher addresses alias.
// - Halt bit, seconds bit 7, stops oscillator and count chain; resets 0.
// - Control bit 7 sets static test pin level; default 1.
// - Control bit 6 enables 512Hz square wave on test pin; default 0.
// - Control bit 5 selects positive (1) or negative calibration; default 1.
// - 64-minute cycle; one second per minute shortened 128 or lengthened 256.
// - Five-bit magnitude adjusts the first twice-magnitude minutes of cycle.
// - Each step adds 512 or removes 256 cycles per 125829120.
// - All time and calendar registers hold BCD tens and units digits.
// - Seconds count 00 to 59, wrap and carry into minutes.
// - Minutes count 00 to 59, wrap and carry into hours.
// - Hours roll 23 to 00, carrying into date and day of week.
// - Year counts 00 to 99; years divisible by four are leap.
// - Both bus lines stay released high while idle.
// - Start and stop are data edges while clock line is high.
// - Data changes only while clock low; sampled while clock high.
// - Device answers only bus address byte D0h write, D1h read.
// - Register pointer increments after each data byte, writes and reads.
// - Receiver acknowledges each byte low; master ends read with no ack.
`timescale 1ns/1ns
`include "rtc_map.svh"
module rtc_calendar_calibration_core (
	input  wire logic i_clk,                  // System clock, 50 MHz
	input  wire logic i_rstn,                 // Synchronous reset, active low
	input  wire logic i_link_clk,             // Bus oversampling clock
	input  wire logic i_osc,                  // 32.768 kHz oscillator pin
	input  wire logic i_scl,                  // Bus clock pin
	input  wire logic i_sda_i,                // Bus data pin level
	output logic      o_sda_o,                // Bus data drive value
	output logic      o_sda_oe,               // Bus data pull-down enable
	output logic      o_test_or_level_pin_o,  // Test pin drive value
	output logic      o_test_or_level_pin_oe, // Test pin pull-down enable
	output logic      o_osc_run               // Oscillator enable
);
	logic       osc_s1, osc_s2, osc_s3, osc_edge;
	logic       req_s1, req_s2, req_s3, req_evt, wr_stb;
	logic       link_req_tgl, link_req_we, ack_tgl_r;
	logic [5:0] link_req_addr;
	logic [7:0] link_req_wdata, rdata_r, rdata_nxt;
	logic       oscillator_halt_bit_r, test_tone_enable_bit_r;
	logic       pin_level_bit_r, cal_sign_r, pin_oe_r;
	logic [4:0] cal_mag_r;
	logic [7:0] sec_r, min_r, hour_r, dow_r, date_r, mon_r, year_r;
	logic [15:0] presc_r, period_m1;
	logic [5:0] cal_min_r, tone_cnt_r;
	logic       adj_now, sec_tick, c_sec, c_min, c_hour, c_date, c_mon;
	logic [7:0] last_day;

	// Next BCD value with wrap; out-of-range values also wrap
	function automatic logic [7:0] bcd_inc(input logic [7:0] v,
	                                      input logic [7:0] lo,
	                                      input logic [7:0] hi);
		if (v >= hi)
			bcd_inc = lo;
		else if (v[3:0] == `BCD_NINE)
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		else
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
	endfunction

	// Leap when the BCD year is a multiple of four, 00 included
	function automatic logic leap_year(input logic [7:0] y);
		if (y[4])
			leap_year = (y[3:0] == `LEAP_U2) || (y[3:0] == `LEAP_U6);
		else
			leap_year = (y[3:0] == `LEAP_U0) || (y[3:0] == `LEAP_U4) ||
			            (y[3:0] == `LEAP_U8);
	endfunction

	// Last day of the current month
	always_comb begin
		case (mon_r)
		`FEB:                    last_day = leap_year(year_r) ?
		                                    `DAYS_29 : `DAYS_28;
		`APR, `JUN, `SEP, `NOV: last_day = `DAYS_30;
		default:                last_day = `DAYS_31;
		endcase
	end

	// Bus framing runs on the link clock
	rtc_i2c_link u_link (
		.i_link_clk  (i_link_clk),
		.i_rstn      (i_rstn),
		.i_scl       (i_scl),
		.i_sda_i     (i_sda_i),
		.o_sda_o     (o_sda_o),
		.o_sda_oe    (o_sda_oe),
		.o_req_tgl   (link_req_tgl),
		.o_req_we    (link_req_we),
		.o_req_addr  (link_req_addr),
		.o_req_wdata (link_req_wdata),
		.i_ack_tgl   (ack_tgl_r),
		.i_rdata     (rdata_r)
	);

	// Request toggle crosses on two flops; fields are held until the ack
	always_ff @(posedge i_clk) begin
		{req_s1, req_s2, req_s3} <= {link_req_tgl, req_s1, req_s2};
	end
	assign req_evt = req_s2 ^ req_s3;
	assign wr_stb  = req_evt & link_req_we;

	// Answer every request once; read data loads on the same edge that toggles the ack
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			rdata_r   <= `BCD_ZERO;
			ack_tgl_r <= 1'b0;
		end else if (req_evt) begin
			rdata_r   <= rdata_nxt;
			ack_tgl_r <= ~ack_tgl_r;
		end
	end

	// Read map; unused indices read zero
	always_comb begin
		case (link_req_addr)
		`REG_SEC:  rdata_nxt = {oscillator_halt_bit_r,
		                        sec_r[6:0]};
		`REG_MIN:  rdata_nxt = min_r & `MIN_MASK;
		`REG_HOUR: rdata_nxt = hour_r;
		`REG_DOW:  rdata_nxt = dow_r;
		`REG_DATE: rdata_nxt = date_r;
		`REG_MON:  rdata_nxt = mon_r;
		`REG_YEAR: rdata_nxt = year_r;
		`REG_CTRL: rdata_nxt = {pin_level_bit_r, test_tone_enable_bit_r,
		                        cal_sign_r, cal_mag_r};
		default:   rdata_nxt = `BCD_ZERO;
		endcase
	end

	// Oscillator pin passes two flops before the edge detector
	always_ff @(posedge i_clk) begin
		{osc_s1, osc_s2, osc_s3} <= {i_osc, osc_s1, osc_s2};
	end
	// Halt freezes everything fed by oscillator cycles
	assign osc_edge  = osc_s2 & ~osc_s3 & ~oscillator_halt_bit_r;
	assign o_osc_run = ~oscillator_halt_bit_r;

	// Control register; magnitude resets to zero so no trim after reset
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			pin_level_bit_r        <= 1'(`CTRL_RST >> `LEVEL_BIT);
			test_tone_enable_bit_r <= 1'b0;
			cal_sign_r             <= 1'b1;
			cal_mag_r              <= 5'h00;
		end else if (wr_stb && link_req_addr == `REG_CTRL) begin
			pin_level_bit_r        <= link_req_wdata[`LEVEL_BIT];
			test_tone_enable_bit_r <= link_req_wdata[`TONE_BIT];
			cal_sign_r             <= link_req_wdata[`SIGN_BIT];
			cal_mag_r              <= 5'(link_req_wdata & `MAG_MASK);
		end
	end

	// Trim one second per minute in the leading 2*magnitude minutes
	assign adj_now = (sec_r == `BCD_ZERO) &&
	                 (cal_min_r < {cal_mag_r, 1'b0});
	// Positive lengthens by 256, negative shortens by 128
	assign period_m1 = !adj_now ? `SEC_NOM_M1 :
	                   cal_sign_r ? `SEC_NOM_M1 + `CAL_LONG :
	                                `SEC_NOM_M1 - `CAL_SHORT;
	assign sec_tick  = osc_edge && (presc_r >= period_m1);

	// Carry chain through the calendar
	assign c_sec  = sec_tick && (sec_r >= `SEC_MAX);
	assign c_min  = c_sec && (min_r >= `SEC_MAX);
	assign c_hour = c_min && (hour_r >= `HOUR_MAX);
	assign c_date = c_hour && (date_r >= last_day);
	assign c_mon  = c_date && (mon_r >= `MON_MAX);

	// Prescaler restarts on a seconds write so a set time starts whole
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			presc_r <= 16'h0000;
		else if (wr_stb && link_req_addr == `REG_SEC)
			presc_r <= 16'h0000;
		else if (sec_tick)
			presc_r <= 16'h0000;
		else if (osc_edge)
			presc_r <= presc_r + 16'h0001;
	end

	// Position in the 64-minute cycle; six bits wrap at 64
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			cal_min_r <= 6'h00;
		else if (c_sec)
			cal_min_r <= cal_min_r + 6'h01;
	end

	// Seconds and halt bit
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			sec_r                 <= `BCD_ZERO;
			oscillator_halt_bit_r <= 1'b0;
		end else if (wr_stb && link_req_addr == `REG_SEC) begin
			sec_r                 <= link_req_wdata & `SEC_MASK;
			oscillator_halt_bit_r <= link_req_wdata[`HALT_BIT];
		end else if (sec_tick) begin
			sec_r <= bcd_inc(sec_r, `BCD_ZERO, `SEC_MAX);
		end
	end

	// Minutes
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			min_r <= `BCD_ZERO;
		else if (wr_stb && link_req_addr == `REG_MIN)
			min_r <= link_req_wdata & `MIN_MASK;
		else if (c_sec)
			min_r <= bcd_inc(min_r, `BCD_ZERO, `SEC_MAX);
	end

	// Hours, 24-hour only
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			hour_r <= `BCD_ZERO;
		else if (wr_stb && link_req_addr == `REG_HOUR)
			hour_r <= link_req_wdata & `HOUR_MASK;
		else if (c_min)
			hour_r <= bcd_inc(hour_r, `BCD_ZERO, `HOUR_MAX);
	end

	// Day of week, 1 to 7
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			dow_r <= `BCD_ONE;
		else if (wr_stb && link_req_addr == `REG_DOW)
			dow_r <= link_req_wdata & `DOW_MASK;
		else if (c_hour)
			dow_r <= bcd_inc(dow_r, `BCD_ONE, `DOW_MAX);
	end

	// Date; an illegal written date still rolls at month end
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			date_r <= `BCD_ONE;
		else if (wr_stb && link_req_addr == `REG_DATE)
			date_r <= link_req_wdata & `DATE_MASK;
		else if (c_hour)
			date_r <= bcd_inc(date_r, `BCD_ONE, last_day);
	end

	// Month
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			mon_r <= `BCD_ONE;
		else if (wr_stb && link_req_addr == `REG_MON)
			mon_r <= link_req_wdata & `MON_MASK;
		else if (c_date)
			mon_r <= bcd_inc(mon_r, `BCD_ONE, `MON_MAX);
	end

	// Year
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			year_r <= `BCD_ZERO;
		else if (wr_stb && link_req_addr == `REG_YEAR)
			year_r <= link_req_wdata;
		else if (c_mon)
			year_r <= bcd_inc(year_r, `BCD_ZERO, `YEAR_MAX);
	end

	// 512 Hz is the oscillator divided by 64
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			tone_cnt_r <= 6'h00;
		else if (osc_edge)
			tone_cnt_r <= tone_cnt_r + 6'h01;
	end

	// Open-drain pin: tone wins over the static level
	always_ff @(posedge i_clk) begin
		if (!i_rstn)
			pin_oe_r <= 1'b0;
		else if (test_tone_enable_bit_r)
			pin_oe_r <= ~tone_cnt_r[`TONE_DIV_BIT];
		else
			pin_oe_r <= ~pin_level_bit_r;
	end
	assign o_test_or_level_pin_o  = 1'b0;
	assign o_test_or_level_pin_oe = pin_oe_r;

	// Halted chain holds seconds and prescaler still
	AST_HALT_FREEZE: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(oscillator_halt_bit_r && !wr_stb) |=> $stable(sec_r) && $stable(presc_r))
		else $error("count chain moved while halted");
	// Seconds wrap and carry
	AST_SEC_WRAP: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(sec_tick && sec_r == `SEC_MAX && !wr_stb) |=>
		sec_r == `BCD_ZERO && min_r != $past(min_r))
		else $error("seconds did not wrap with carry");
	// Minutes wrap and carry
	AST_MIN_WRAP: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(c_sec && min_r == `SEC_MAX && !wr_stb) |=>
		min_r == `BCD_ZERO && hour_r != $past(hour_r))
		else $error("minutes did not wrap with carry");
	// Hour rollover feeds date and weekday together
	AST_HOUR_CARRY: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(c_min && hour_r == `HOUR_MAX && !wr_stb) |=> hour_r == `BCD_ZERO &&
		date_r != $past(date_r) && dow_r != $past(dow_r))
		else $error("hour rollover lost a carry");
	// Date returns to first of month
	AST_DATE_WRAP: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(c_date && !wr_stb) |=> date_r == `BCD_ONE)
		else $error("date did not roll to 01");
	// Month returns to January and bumps the year
	AST_MON_WRAP: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(c_mon && !wr_stb) |=> mon_r == `BCD_ONE && year_r != $past(year_r))
		else $error("month did not roll to 01");
	// Seconds stay legal BCD when counted from legal values
	AST_SEC_BCD: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(sec_tick && sec_r <= `SEC_MAX && sec_r[3:0] <= `BCD_NINE &&
		!wr_stb) |=>
		sec_r[3:0] <= `BCD_NINE && sec_r <= `SEC_MAX)
		else $error("seconds left BCD range");
	// A second of odd length ends only in second 00 of an eligible minute;
	// judged from the prescaler, so a broken trim select is caught
	AST_CAL_WINDOW: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(sec_tick && presc_r != `SEC_NOM_M1) |->
		(sec_r == `BCD_ZERO) && (cal_min_r < `CAL_MIN_ELIG))
		else $error("calibration outside eligible minutes");
	// Static level seen one cycle later when no tone
	AST_PIN_LEVEL: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(!test_tone_enable_bit_r && $stable(pin_level_bit_r)) |=>
		pin_oe_r == ~$past(pin_level_bit_r))
		else $error("test pin does not follow level bit");
	// Tone overrides level
	AST_TONE_PRIO: assert property (@(posedge i_clk) disable iff (!i_rstn)
		test_tone_enable_bit_r |=> pin_oe_r == ~$past(tone_cnt_r[`TONE_DIV_BIT]))
		else $error("tone did not override level");
	COV_SEC_WRAP: cover property (@(posedge i_clk) disable iff (!i_rstn) c_sec);
	COV_CAL_LONG: cover property (@(posedge i_clk) disable iff (!i_rstn)
		sec_tick && adj_now && cal_sign_r);
	COV_CTRL_WRITE: cover property (@(posedge i_clk) disable iff (!i_rstn)
		wr_stb && link_req_addr == `REG_CTRL);
	COV_TONE: cover property (@(posedge i_clk) disable iff (!i_rstn)
		test_tone_enable_bit_r && $rose(pin_oe_r));
endmodule // rtc_calendar_calibration_core

// >>> rtc_map.svh
// Register map, field layout, reset values and timing counts of the RTC core
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// Register indices (low six address bits only)
`define REG_SEC      6'h00
`define REG_MIN      6'h01
`define REG_HOUR     6'h02
`define REG_DOW      6'h03
`define REG_DATE     6'h04
`define REG_MON      6'h05
`define REG_YEAR     6'h06
`define REG_CTRL     6'h07

// Two-wire bus address, 7 bits (write byte D0h, read byte D1h)
`define DEV_ADDR     7'h68
`define BYTE_BITS    4'h8

// Field positions
`define HALT_BIT     7
`define LEVEL_BIT    7
`define TONE_BIT     6
`define SIGN_BIT     5
`define TONE_DIV_BIT 5

// Writable field masks
`define SEC_MASK     8'h7F
`define MIN_MASK     8'h7F
`define HOUR_MASK    8'h3F
`define DOW_MASK     8'h07
`define DATE_MASK    8'h3F
`define MON_MASK     8'h1F
`define MAG_MASK     8'h1F

// Reset values
`define CTRL_RST     8'hA0
`define BCD_ZERO     8'h00
`define BCD_ONE      8'h01

// BCD counting limits
`define BCD_NINE     4'h9
`define SEC_MAX      8'h59
`define HOUR_MAX     8'h23
`define DOW_MAX      8'h07
`define MON_MAX      8'h12
`define YEAR_MAX     8'h99
`define FEB          8'h02
`define APR          8'h04
`define JUN          8'h06
`define SEP          8'h09
`define NOV          8'h11
`define DAYS_28      8'h28
`define DAYS_29      8'h29
`define DAYS_30      8'h30
`define DAYS_31      8'h31
`define LEAP_U0      4'h0
`define LEAP_U2      4'h2
`define LEAP_U4      4'h4
`define LEAP_U6      4'h6
`define LEAP_U8      4'h8

// Oscillator cycles per second, minus one, and calibration adjustments
`define SEC_NOM_M1   16'h7FFF
`define CAL_SHORT    16'h0080
`define CAL_LONG     16'h0100
// Cycle minutes 62 and 63 are never trimmed
`define CAL_MIN_ELIG 6'h3E

`endif

// >>> rtc_pkg.sv
// Types of the RTC core's two-wire link
package rtc_pkg;
	typedef enum {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR,
		ST_WR_ACK,
		ST_RD,
		ST_RD_ACK
	} link_state_t;
endpackage

// >>> rtc_i2c_link.sv
// Two-wire bus slave on the link clock: framing, address match, pointer
`timescale 1ns/1ns
`include "rtc_map.svh"
module rtc_i2c_link (
	input  wire logic       i_link_clk,  // Link oversampling clock
	input  wire logic       i_rstn,      // Reset, active low, async source
	input  wire logic       i_scl,       // Bus clock pin
	input  wire logic       i_sda_i,     // Bus data pin level
	output logic            o_sda_o,     // Data drive value, always low
	output logic            o_sda_oe,    // Data pull-down enable
	output logic            o_req_tgl,   // Request toggle to core
	output logic            o_req_we,    // Request is a write
	output logic [5:0]      o_req_addr,  // Register index
	output logic [7:0]      o_req_wdata, // Write data
	input  wire logic       i_ack_tgl,   // Core done toggle
	input  wire logic [7:0] i_rdata      // Read data, stable after ack
);
	logic                 rst_s1, rst_s2, scl_s1, scl_s2, scl_s3;
	logic                 sda_s1, sda_s2, sda_s3, ack_s1, ack_s2;
	logic                 scl_rise, scl_fall, start_c, stop_c, busy;
	logic                 first_r, rw_r, sda_oe_r, req_tgl_r, req_we_r;
	logic [3:0]           bit_r;
	logic [7:0]           sh_r, req_wdata_r;
	logic [5:0]           ptr_r, req_addr_r;
	rtc_pkg::link_state_t state_r;

	// Reset and pins pass two flops before any logic looks at them
	always_ff @(posedge i_link_clk) begin
		rst_s1 <= i_rstn;
		rst_s2 <= rst_s1;
		{scl_s1, scl_s2, scl_s3} <= {i_scl, scl_s1, scl_s2};
		{sda_s1, sda_s2, sda_s3} <= {i_sda_i, sda_s1, sda_s2};
		{ack_s1, ack_s2} <= {i_ack_tgl, ack_s1};
	end

	// Data edges while the clock is high are frame conditions
	assign scl_rise = scl_s2 & ~scl_s3;
	assign scl_fall = ~scl_s2 & scl_s3;
	assign start_c  = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
	assign stop_c   = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
	assign busy     = req_tgl_r ^ ack_s2;

	// Byte engine: sample on clock rise, change data on clock fall
	always_ff @(posedge i_link_clk) begin
		if (!rst_s2) begin
			state_r     <= rtc_pkg::ST_IDLE;
			bit_r       <= 4'h0;
			sh_r        <= 8'h00;
			ptr_r       <= 6'h00;
			first_r     <= 1'b0;
			rw_r        <= 1'b0;
			sda_oe_r    <= 1'b0;
			req_tgl_r   <= 1'b0;
			req_we_r    <= 1'b0;
			req_addr_r  <= 6'h00;
			req_wdata_r <= 8'h00;
		end else if (start_c) begin
			state_r  <= rtc_pkg::ST_ADDR;
			bit_r    <= 4'h0;
			first_r  <= 1'b1;
			sda_oe_r <= 1'b0;
		end else if (stop_c) begin
			state_r  <= rtc_pkg::ST_IDLE;
			sda_oe_r <= 1'b0;
		end else begin
			case (state_r)
			rtc_pkg::ST_ADDR, rtc_pkg::ST_WR: begin
				if (scl_rise && bit_r != `BYTE_BITS) begin
					sh_r  <= {sh_r[6:0], sda_s2};
					bit_r <= bit_r + 4'h1;
				end else if (scl_fall && bit_r == `BYTE_BITS) begin
					bit_r <= 4'h0;
					if (state_r == rtc_pkg::ST_WR) begin
						sda_oe_r <= 1'b1;
						state_r  <= rtc_pkg::ST_WR_ACK;
						if (first_r) begin
							ptr_r   <= sh_r[5:0];
							first_r <= 1'b0;
						end else begin
							req_tgl_r   <= ~req_tgl_r;
							req_we_r    <= 1'b1;
							req_addr_r  <= ptr_r;
							req_wdata_r <= sh_r;
							ptr_r       <= ptr_r + 6'h01;
						end
					end else if (sh_r[7:1] == `DEV_ADDR) begin
						sda_oe_r <= 1'b1;
						rw_r     <= sh_r[0];
						state_r  <= rtc_pkg::ST_ADDR_ACK;
						if (sh_r[0]) begin
							req_tgl_r  <= ~req_tgl_r;
							req_we_r   <= 1'b0;
							req_addr_r <= ptr_r;
							ptr_r      <= ptr_r + 6'h01;
						end
					end else begin
						state_r <= rtc_pkg::ST_IDLE;
					end
				end
			end
			rtc_pkg::ST_ADDR_ACK, rtc_pkg::ST_RD_ACK: begin
				if (scl_rise && state_r == rtc_pkg::ST_RD_ACK) begin
					if (sda_s2) begin
						state_r <= rtc_pkg::ST_IDLE;
					end else begin
						req_tgl_r  <= ~req_tgl_r;
						req_we_r   <= 1'b0;
						req_addr_r <= ptr_r;
						ptr_r      <= ptr_r + 6'h01;
					end
				end else if (scl_fall) begin
					if (rw_r) begin
						sh_r     <= {i_rdata[6:0], 1'b0};
						sda_oe_r <= ~i_rdata[7];
						bit_r    <= 4'h1;
						state_r  <= rtc_pkg::ST_RD;
					end else begin
						sda_oe_r <= 1'b0;
						bit_r    <= 4'h0;
						state_r  <= rtc_pkg::ST_WR;
					end
				end
			end
			rtc_pkg::ST_WR_ACK: begin
				if (scl_fall) begin
					sda_oe_r <= 1'b0;
					state_r  <= rtc_pkg::ST_WR;
				end
			end
			rtc_pkg::ST_RD: begin
				if (scl_fall && bit_r == `BYTE_BITS) begin
					sda_oe_r <= 1'b0;
					state_r  <= rtc_pkg::ST_RD_ACK;
				end else if (scl_fall) begin
					sda_oe_r <= ~sh_r[7];
					sh_r     <= {sh_r[6:0], 1'b0};
					bit_r    <= bit_r + 4'h1;
				end
			end
			default: state_r <= rtc_pkg::ST_IDLE;
			endcase
		end
	end

	assign o_sda_o     = 1'b0;
	assign o_sda_oe    = sda_oe_r;
	assign o_req_tgl   = req_tgl_r;
	assign o_req_we    = req_we_r;
	assign o_req_addr  = req_addr_r;
	assign o_req_wdata = req_wdata_r;

	// Idle bus is never pulled low by us
	AST_IDLE_RELEASE: assert property (@(posedge i_link_clk) disable iff (!rst_s2)
		state_r == rtc_pkg::ST_IDLE |-> !sda_oe_r)
		else $error("data line held low while idle");
	// Next read byte must be fetched before it is shifted out
	AST_FETCH_READY: assert property (@(posedge i_link_clk) disable iff (!rst_s2)
		(state_r == rtc_pkg::ST_RD_ACK && scl_fall) |-> !busy)
		else $error("read data not ready at byte start");
	COV_READ_ACKED: cover property (@(posedge i_link_clk) disable iff (!rst_s2)
		state_r == rtc_pkg::ST_RD_ACK && scl_rise && !sda_s2);
endmodule // rtc_i2c_link

// >>> i2c_master_model.sv
// Two-wire bus master model for the bench
`timescale 1ns/1ns
module i2c_master_model (
	input  wire logic i_clk,   // Paces the bus
	input  wire logic i_sda,   // Resolved data line
	output logic      o_scl,   // Clock line
	output logic      o_sda_oe // High pulls data low
);
	// Both lines released at rest
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	// A third of a bit, well above the slave's oversampling need
	task automatic hp;
		repeat (25) @(posedge i_clk);
	endtask
	// Also a repeated start when entered with clock low
	task automatic start;
		o_sda_oe <= 1'b0;
		hp();
		o_scl <= 1'b1;
		hp();
		o_sda_oe <= 1'b1;
		hp();
		o_scl <= 1'b0;
		hp();
	endtask
	task automatic stop;
		o_sda_oe <= 1'b1;
		hp();
		o_scl <= 1'b1;
		hp();
		o_sda_oe <= 1'b0;
		hp();
	endtask
	// Eight bits MSB first, then the ack bit; data moves with clock low
	task automatic xfer(input logic [7:0] d, input logic nack,
		output logic [7:0] q, output logic ack);
		logic [8:0] v;
		logic [8:0] s;
		v = {d, nack};
		for (int i = 8; i >= 0; i--) begin
			o_sda_oe <= ~v[i];
			hp();
			o_scl <= 1'b1;
			hp();
			s[i] = i_sda;
			o_scl <= 1'b0;
			hp();
		end
		q = s[8:1];
		ack = s[0];
	endtask
endmodule // i2c_master_model

// >>> testbench.sv
// Self-checking bench for the RTC core
`timescale 1ns/1ns
module testbench;
	logic       i_clk = 1'b0;
	logic       i_link_clk = 1'b0;
	logic       i_rstn = 1'b0;
	logic       i_osc = 1'b0;
	logic       scl, m_oe, sda, sda_o, sda_oe, pin_o, pin_oe, run;
	int         err_total = 0;
	int         n_tests = 0;
	int         cyc = 0;
	int         cnt;
	logic       last, a;
	logic [7:0] q;
	logic [7:0] rb[$];
	// Rows: control byte, expected pin pull-down
	logic [8:0] rows[3] = '{9'h07F, 9'h001, 9'h100};
	logic [7:0] cal[7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h00};
	always #10 i_clk = ~i_clk;
	initial begin
		#7;
		forever #15 i_link_clk = ~i_link_clk;
	end
	// Fast oscillator keeps a second near 65536 clocks
	always @(posedge i_clk) i_osc <= ~i_osc;
	assign sda = ~(sda_oe | m_oe);
	rtc_calendar_calibration_core DUT (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_link_clk(i_link_clk), .i_osc(i_osc), .i_scl(scl),
		.i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
		.o_test_or_level_pin_o(pin_o), .o_test_or_level_pin_oe(pin_oe),
		.o_osc_run(run));
	i2c_master_model M (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
		.o_sda_oe(m_oe));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		if (err_total == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
		M.start();
		M.xfer(8'hD0, 1'b1, q, a);
		chk({7'h00, a}, 8'h00);
		M.xfer(p, 1'b1, q, a);
		foreach (d[i]) begin
			M.xfer(d[i], 1'b1, q, a);
			chk({7'h00, a}, 8'h00);
		end
		M.stop();
	endtask
	// Point, restart for reading, last byte left unacknowledged
	task automatic rd(input logic [7:0] p, input int n);
		rb = {};
		M.start();
		M.xfer(8'hD0, 1'b1, q, a);
		M.xfer(p, 1'b1, q, a);
		M.start();
		M.xfer(8'hD1, 1'b1, q, a);
		for (int i = 0; i < n; i++) begin
			M.xfer(8'hFF, (i == n - 1), q, a);
			rb.push_back(q);
		end
		M.stop();
	endtask
	// Hang guard
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 110000) begin
			err_total++;
			results();
		end
	end
	initial begin
		repeat (16) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (20) @(posedge i_clk);
		chk({6'h00, pin_oe, run}, 8'h01);
		chk({6'h00, sda_o, pin_o}, 8'h00);
		rd(8'h07, 1);
		chk(rb[0], 8'hA0);
		foreach (rows[i]) begin
			wr(8'h47, {rows[i][8:1]});
			rd(8'h07, 1);
			chk(rb[0], rows[i][8:1]);
			chk({7'h00, pin_oe}, {7'h00, rows[i][0]});
		end
		// Tone with level high: pin must toggle every 32 osc cycles
		wr(8'h07, {8'hC0});
		cnt = 0;
		last = pin_oe;
		repeat (2048) begin
			@(posedge i_clk);
			if (pin_oe !== last) cnt++;
			last = pin_oe;
		end
		chk({7'h00, cnt inside {[31:33]}}, 8'h01);
		wr(8'h07, {8'h80});
		chk({7'h00, pin_oe}, 8'h00);
		// Foreign address must be left unanswered
		M.start();
		M.xfer(8'hA0, 1'b1, q, a);
		M.stop();
		chk({7'h00, a}, 8'h01);
		wr(8'h00, {8'h80});
		chk({7'h00, run}, 8'h00);
		// One second from the last moment of 28 February in a leap year
		wr(8'h00, {8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h00});
		repeat (63000) @(posedge i_clk);
		rd(8'h00, 7);
		foreach (cal[i]) chk(rb[i], cal[i]);
		chk({7'h00, run}, 8'h01);
		results();
	end
endmodule // testbench
